// File: vic_pkg.sv
// Constants and types for the interrupt controller.
package vic_pkg;

	// =========================================================================
	// Table layout.
	localparam int TRAP_COUNT = 8;
	localparam int IRQ_COUNT = 118;
	localparam int TABLE_ENTRIES = 126;
	localparam int INDEX_W = 7;
	localparam int LEVEL_W = 3;
	localparam int ADDR_W = 24;
	localparam logic [INDEX_W-1:0] IRQ_FIRST_INDEX = 7'h08;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h00_0000;
	localparam logic [ADDR_W-1:0] TABLE_BASE = 24'h00_0004;
	localparam logic [ADDR_W-1:0] ALT_OFFSET = 24'h00_0100;
	localparam logic [LEVEL_W-1:0] LEVEL_OFF = 3'h0;

	// =========================================================================
	// Timing counts in cycles of the reference clock.
	localparam int MEM_LATENCY = 2;
	localparam int ENTRY_CYCLES = 5;
	localparam int RETURN_CYCLES = 3;
	localparam int COUNT_W = 8;

	// =========================================================================
	// Entry sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_ENTER = 3'b100
	} entry_state_t;

endpackage

// File: vector_resolver.sv
// Priority resolution across traps and levelled interrupt sources.
`timescale 1ns/1ps
module vector_resolver #(
	parameter int N_IRQ = vic_pkg::IRQ_COUNT
) (
	// Clock and reset, used only by checks.
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Requests.
	input wire logic [vic_pkg::TRAP_COUNT-1:0] i_trap_req,
	input wire logic [N_IRQ-1:0] i_irq_req,
	input wire logic [N_IRQ-1:0] i_irq_enable,
	input wire logic [N_IRQ*vic_pkg::LEVEL_W-1:0] i_irq_level,
	input wire logic [vic_pkg::LEVEL_W-1:0] i_cpu_level,
	// Winner.
	output logic o_valid,
	output logic o_is_trap,
	output logic [vic_pkg::INDEX_W-1:0] o_index,
	output logic [vic_pkg::LEVEL_W-1:0] o_level
);

	logic [N_IRQ-1:0] eligible;
	logic [vic_pkg::LEVEL_W-1:0] lvl [N_IRQ];
	logic irq_found;
	logic [vic_pkg::LEVEL_W-1:0] best_lvl;
	logic [vic_pkg::INDEX_W-1:0] best_src;
	logic trap_found;
	logic [2:0] trap_idx;
	logic bad_level;
	logic bad_tie;

	// =========================================================================
	// Per source masking by enable and by the core level.
	for (genvar g = 0; g < N_IRQ; g++) begin : g_src
		assign lvl[g] = i_irq_level[g*vic_pkg::LEVEL_W +: vic_pkg::LEVEL_W];
		assign eligible[g] = i_irq_req[g] && i_irq_enable[g] &&
			(lvl[g] != vic_pkg::LEVEL_OFF) && (lvl[g] > i_cpu_level);
	end

	// =========================================================================
	// Scan from the top so that on equal level the lower vector wins.
	always_comb begin
		irq_found = 1'b0;
		best_lvl = vic_pkg::LEVEL_OFF;
		best_src = '0;
		for (int i = N_IRQ - 1; i >= 0; i--) begin
			if (eligible[i] && (!irq_found || lvl[i] >= best_lvl)) begin
				irq_found = 1'b1;
				best_lvl = lvl[i];
				best_src = 7'(i);
			end
		end
	end

	always_comb begin
		trap_found = 1'b0;
		trap_idx = 3'h0;
		for (int i = vic_pkg::TRAP_COUNT - 1; i >= 0; i--) begin
			if (i_trap_req[i]) begin
				trap_found = 1'b1;
				trap_idx = 3'(i);
			end
		end
	end

	assign o_valid = trap_found || irq_found;
	assign o_is_trap = trap_found;
	// Traps take entries 0 to 7 and source n takes entry 8 plus n.
	assign o_index = trap_found ? {4'h0, trap_idx} :
		vic_pkg::IRQ_FIRST_INDEX + best_src;
	assign o_level = trap_found ? 3'h7 : best_lvl;

	// =========================================================================
	// Checks.
	always_comb begin
		bad_level = 1'b0;
		bad_tie = 1'b0;
		for (int i = 0; i < N_IRQ; i++) begin
			if (eligible[i] && lvl[i] > best_lvl) begin
				bad_level = 1'b1;
			end
			if (eligible[i] && lvl[i] == best_lvl && 7'(i) < best_src) begin
				bad_tie = 1'b1;
			end
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	a_level_highest: assert property (irq_found |-> !bad_level)
		else $error("a lower level source was chosen");
	a_tie_natural: assert property (irq_found |-> !bad_tie)
		else $error("tie not broken by vector order");
	a_mask_gate: assert property (
		(o_valid && !o_is_trap) |-> (best_lvl > i_cpu_level &&
		i_irq_enable[best_src] && i_irq_req[best_src]))
		else $error("masked source was chosen");
	a_any_pending: assert property ((|eligible || |i_trap_req) |-> o_valid)
		else $error("pending request not reported");

endmodule

// File: vectored_interrupt_controller.sv
// Top of the vectored interrupt controller with entry and return sequencing.
`timescale 1ns/1ps
module vectored_interrupt_controller #(
	parameter int N_IRQ = vic_pkg::IRQ_COUNT,
	parameter int MEM_LAT = vic_pkg::MEM_LATENCY,
	parameter int ENTRY_LAT = vic_pkg::ENTRY_CYCLES,
	parameter int RETURN_LAT = vic_pkg::RETURN_CYCLES
) (
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Event sources.
	input wire logic [vic_pkg::TRAP_COUNT-1:0] i_trap_req,
	input wire logic [N_IRQ-1:0] i_irq_req,
	input wire logic [N_IRQ-1:0] i_irq_enable,
	input wire logic [N_IRQ*vic_pkg::LEVEL_W-1:0] i_irq_level,
	// Core state and table select.
	input wire logic [vic_pkg::LEVEL_W-1:0] i_cpu_level,
	input wire logic i_alt_table_select,
	// Request to the core.
	output logic o_int_req,
	input wire logic i_int_ack,
	output logic [vic_pkg::INDEX_W-1:0] o_vector_num,
	output logic [vic_pkg::LEVEL_W-1:0] o_taken_level,
	output logic o_taken_trap,
	// Vector fetch from program memory.
	output logic o_fetch_req,
	output logic [vic_pkg::ADDR_W-1:0] o_fetch_addr,
	input wire logic [vic_pkg::ADDR_W-1:0] i_fetch_data,
	// Handler entry.
	output logic o_enter,
	output logic [vic_pkg::ADDR_W-1:0] o_handler_addr,
	// Handler return.
	input wire logic i_return_req,
	output logic o_return_busy,
	output logic o_return_done
);

	localparam int ENTRY_SPAN = ENTRY_LAT + 1;
	localparam int RET_SPAN = RETURN_LAT;

	// =========================================================================
	// Parameter checks.
	if (N_IRQ < 1 || N_IRQ > vic_pkg::IRQ_COUNT) begin : g_bad_n
		$error("N_IRQ out of range");
	end
	if (vic_pkg::TRAP_COUNT + vic_pkg::IRQ_COUNT != vic_pkg::TABLE_ENTRIES)
	begin : g_bad_table
		$error("table size mismatch");
	end
	if (MEM_LAT < 1 || MEM_LAT >= ENTRY_LAT) begin : g_bad_mem
		$error("MEM_LAT must lie between 1 and ENTRY_LAT minus 1");
	end
	if (ENTRY_LAT > 255 || RETURN_LAT < 1 || RETURN_LAT > 255)
	begin : g_bad_lat
		$error("latency out of range");
	end

	logic res_valid;
	logic res_trap;
	logic [vic_pkg::INDEX_W-1:0] res_index;
	logic [vic_pkg::LEVEL_W-1:0] res_level;
	vic_pkg::entry_state_t state_q;
	logic [vic_pkg::COUNT_W-1:0] entry_cnt_q;
	logic alt_q;
	logic ack_take;
	logic [vic_pkg::ADDR_W-1:0] entry_addr;
	logic [vic_pkg::COUNT_W-1:0] ret_cnt_q;

	// =========================================================================
	// Priority resolution.
	vector_resolver #(
		.N_IRQ(N_IRQ)
	) u_resolver (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_trap_req(i_trap_req),
		.i_irq_req(i_irq_req),
		.i_irq_enable(i_irq_enable),
		.i_irq_level(i_irq_level),
		.i_cpu_level(i_cpu_level),
		.o_valid(res_valid),
		.o_is_trap(res_trap),
		.o_index(res_index),
		.o_level(res_level)
	);

	// A single request line, offered only while no entry is under way.
	assign o_int_req = res_valid && (state_q == vic_pkg::ST_IDLE);
	assign ack_take = o_int_req && i_int_ack;

	// Entry address is base plus two per entry, moved up for the other table.
	assign entry_addr = vic_pkg::TABLE_BASE + {16'h0000, res_index, 1'b0} +
		(i_alt_table_select ? vic_pkg::ALT_OFFSET : 24'h00_0000);

	// =========================================================================
	// Entry sequencer, fixed length from acknowledge to handler entry.
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			// Reset leaves the sequencer idle; the core starts at RESET_ADDR.
			state_q <= vic_pkg::ST_IDLE;
			entry_cnt_q <= '0;
		end else begin
			case (state_q)
				vic_pkg::ST_IDLE: begin
					entry_cnt_q <= '0;
					if (ack_take) begin
						state_q <= vic_pkg::ST_FETCH;
					end
				end
				vic_pkg::ST_FETCH: begin
					entry_cnt_q <= entry_cnt_q + 8'h01;
					if (entry_cnt_q == 8'(ENTRY_LAT - 1)) begin
						state_q <= vic_pkg::ST_ENTER;
					end
				end
				vic_pkg::ST_ENTER: begin
					state_q <= vic_pkg::ST_IDLE;
				end
				default: begin
					state_q <= vic_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Winner and table choice are frozen at the acknowledge.
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_vector_num <= '0;
			o_taken_level <= '0;
			o_taken_trap <= 1'b0;
			o_fetch_addr <= vic_pkg::TABLE_BASE;
			alt_q <= 1'b0;
		end else if (ack_take) begin
			o_vector_num <= res_index;
			o_taken_level <= res_level;
			o_taken_trap <= res_trap;
			o_fetch_addr <= entry_addr;
			alt_q <= i_alt_table_select;
		end
	end

	assign o_fetch_req = (state_q == vic_pkg::ST_FETCH) && (entry_cnt_q == '0);

	// The 24-bit entry word becomes the handler start address.
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_handler_addr <= '0;
		end else if (state_q == vic_pkg::ST_FETCH &&
			entry_cnt_q == 8'(MEM_LAT)) begin
			o_handler_addr <= i_fetch_data;
		end
	end

	assign o_enter = (state_q == vic_pkg::ST_ENTER);

	// =========================================================================
	// Return sequencer, fixed length from request to completion.
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_return_busy <= 1'b0;
			ret_cnt_q <= '0;
		end else if (!o_return_busy) begin
			ret_cnt_q <= '0;
			if (i_return_req) begin
				o_return_busy <= 1'b1;
			end
		end else if (o_return_done) begin
			o_return_busy <= 1'b0;
			ret_cnt_q <= '0;
		end else begin
			ret_cnt_q <= ret_cnt_q + 8'h01;
		end
	end

	assign o_return_done = o_return_busy &&
		(ret_cnt_q == 8'(RETURN_LAT - 1));

	// =========================================================================
	// Checks.
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	a_single_req: assert property (
		o_int_req |-> state_q == vic_pkg::ST_IDLE ##1
		(!o_int_req || !$past(i_int_ack)))
		else $error("request offered during an entry");
	a_entry_latency: assert property (
		ack_take |-> !o_enter ##ENTRY_SPAN o_enter)
		else $error("entry latency is not fixed");
	a_return_latency: assert property (
		(i_return_req && !o_return_busy) |-> ##RET_SPAN o_return_done)
		else $error("return latency is not fixed");
	a_prim_addr: assert property (
		(ack_take && !i_alt_table_select) |=> o_fetch_addr ==
		24'h00_0004 + {16'h0000, $past(res_index), 1'b0})
		else $error("primary entry address wrong");
	a_alt_addr: assert property (
		(ack_take && i_alt_table_select) |=> o_fetch_addr ==
		24'h00_0104 + {16'h0000, $past(res_index), 1'b0})
		else $error("alternate entry address wrong");
	a_trap_first: assert property (
		(ack_take && |i_trap_req) |=> o_taken_trap &&
		o_vector_num < 7'h08)
		else $error("trap not taken first");
	a_handler_word: assert property (
		o_fetch_req ##(MEM_LAT) 1'b1 |=>
		o_handler_addr == $past(i_fetch_data))
		else $error("handler address not from table");

	c_trap_entry: cover property (ack_take && |i_trap_req);
	c_alt_entry: cover property (ack_take && i_alt_table_select);
	c_irq_entry: cover property (o_enter && !o_taken_trap);
	c_return: cover property (o_return_done);

endmodule

// File: program_memory_model.sv
// Program memory model that answers vector fetches after a fixed latency.
`timescale 1ns/1ps
module program_memory_model #(
	parameter int MEM_LAT = 2,
	parameter bit ALT_USED = 1'b1,
	// Default handler address is arbitrary.
	parameter logic [23:0] DEFAULT_HANDLER = 24'h00_0200
) (
	// Clock.
	input wire logic i_ref_clk,
	// Fetch request from the controller.
	input wire logic i_fetch_req,
	input wire logic [23:0] i_fetch_addr,
	// Entry word.
	output logic [23:0] o_fetch_data
);
	// =========================================================================
	// Fetch pipeline.
	logic [MEM_LAT-1:0] pend_q = '0;
	logic [23:0] addr_q [MEM_LAT];
	logic [23:0] last_q = 24'h00_0000;

	// Every entry of both tables holds a handler; an unused alternate table
	// mirrors the primary one, and an address below 0x0004 or above 0x01FE answers with the default handler.
	function automatic logic [23:0] entry_word(input logic [23:0] a);
		logic [23:0] w;
		w = a;
		if (!ALT_USED && a >= 24'h00_0104) begin
			w = a - 24'h00_0100;
		end
		if (a < 24'h00_0004 || a > 24'h00_01FE) begin
			entry_word = DEFAULT_HANDLER;
		end else begin
			entry_word = w ^ 24'h3C_0000;
		end
	endfunction

	always_ff @(posedge i_ref_clk) begin
		pend_q[0] <= i_fetch_req;
		addr_q[0] <= i_fetch_addr;
		for (int k = 1; k < MEM_LAT; k++) begin
			pend_q[k] <= pend_q[k-1];
			addr_q[k] <= addr_q[k-1];
		end
		last_q <= o_fetch_data;
	end

	// Outside the answer cycle the bus flips every cycle, so stale data shows.
	assign o_fetch_data = pend_q[MEM_LAT-1] ?
		entry_word(addr_q[MEM_LAT-1]) : ~last_q;
endmodule

// File: vectored_interrupt_controller_test.sv
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ps
module vectored_interrupt_controller_test;
	localparam int N = vic_pkg::IRQ_COUNT;
	localparam int EL = vic_pkg::ENTRY_CYCLES;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] trap = '0;
	logic [N-1:0] req = '0;
	logic [N-1:0] en = '0;
	logic [3*N-1:0] lvl = '0;
	logic [2:0] cpu = 3'h0;
	logic alt = 1'b0;
	logic ack = 1'b0;
	logic ret = 1'b0;
	logic int_req, fetch_req, enter, tk_trap, busy, done;
	logic [6:0] vnum;
	logic [2:0] tk_lvl;
	logic [23:0] faddr, fdata, haddr;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	always #5 ref_clk = ~ref_clk;

	vectored_interrupt_controller i_dut (.i_ref_clk(ref_clk),
		.i_reset(reset), .i_trap_req(trap), .i_irq_req(req),
		.i_irq_enable(en), .i_irq_level(lvl), .i_cpu_level(cpu),
		.i_alt_table_select(alt), .o_int_req(int_req), .i_int_ack(ack),
		.o_vector_num(vnum), .o_taken_level(tk_lvl),
		.o_taken_trap(tk_trap), .o_fetch_req(fetch_req),
		.o_fetch_addr(faddr), .i_fetch_data(fdata), .o_enter(enter),
		.o_handler_addr(haddr), .i_return_req(ret),
		.o_return_busy(busy), .o_return_done(done));

	program_memory_model i_mem (.i_ref_clk(ref_clk),
		.i_fetch_req(fetch_req), .i_fetch_addr(faddr),
		.o_fetch_data(fdata));

	// =========================================================================
	// Shared tasks.
	task automatic chk(input string name, input logic [23:0] exp,
		input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic src(input int n, input logic [2:0] l);
		req[n] = 1'b1;
		en[n] = 1'b1;
		lvl[3*n+:3] = l;
	endtask

	task automatic clear;
		req = '0;
		en = '0;
		lvl = '0;
		trap = '0;
		cpu = 3'h0;
		@(negedge ref_clk);
	endtask

	// Acknowledges at the next edge and follows the whole entry walk.
	task automatic take(input int idx, input logic tr, input logic [2:0] l,
		input logic a);
		logic [23:0] ea;
		ea = 24'h00_0004 + 24'(2 * idx) + (a ? 24'h00_0100 : 24'h00_0000);
		alt = a;
		ack = 1'b1;
		#1;
		chk("int_req", 24'h1, {23'h0, int_req});
		@(negedge ref_clk);
		ack = 1'b0;
		alt = ~a;
		chk("fetch_req", 24'h1, {23'h0, fetch_req});
		chk("fetch_addr", ea, faddr);
		chk("vector", 24'(idx), {17'h0, vnum});
		chk("trap", {23'h0, tr}, {23'h0, tk_trap});
		chk("level", {21'h0, l}, {21'h0, tk_lvl});
		req = '0;
		trap = '0;
		for (int k = 2; k <= EL + 1; k++) begin
			@(negedge ref_clk);
			chk("enter", {23'h0, k == EL + 1}, {23'h0, enter});
		end
		chk("handler", ea ^ 24'h3C_0000, haddr);
		alt = 1'b0;
	endtask

	// =========================================================================
	// Scenarios.
	task automatic t_traps;
		for (int t = 0; t < 8; t++) begin
			clear();
			trap = 8'h80 | (8'h01 << t);
			req[0] = 1'b1;
			lvl[2:0] = 3'h7;
			cpu = 3'h7;
			take(t, 1'b1, 3'h7, t[0]);
		end
	endtask

	task automatic t_levels;
		clear();
		cpu = 3'h1;
		src(5, 3'h2);
		src(100, 3'h6);
		src(40, 3'h6);
		take(48, 1'b0, 3'h6, 1'b0);
		clear();
		src(0, 3'h1);
		take(8, 1'b0, 3'h1, 1'b1);
		clear();
		src(117, 3'h7);
		take(125, 1'b0, 3'h7, 1'b0);
	endtask

	task automatic t_mask;
		clear();
		cpu = 3'h3;
		src(3, 3'h3);
		src(4, 3'h0);
		req[6] = 1'b1;
		lvl[18+:3] = 3'h7;
		ack = 1'b1;
		repeat (3) begin
			@(negedge ref_clk);
			chk("masked req", 24'h0, {23'h0, int_req});
			chk("masked fetch", 24'h0, {23'h0, fetch_req});
		end
		cpu = 3'h2;
		take(11, 1'b0, 3'h3, 1'b0);
	endtask

	task automatic t_return;
		logic [4:0] eb, ed;
		eb = 5'b10111;
		ed = 5'b00100;
		@(negedge ref_clk);
		ret = 1'b1;
		for (int k = 0; k < 5; k++) begin
			@(negedge ref_clk);
			chk("busy", {23'h0, eb[k]}, {23'h0, busy});
			chk("done", {23'h0, ed[k]}, {23'h0, done});
		end
		ret = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk("idle", 24'h0, {23'h0, busy});
	endtask

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
		t_traps();
		t_levels();
		t_mask();
		t_return();
		conclude();
	end
endmodule
